// [rtl/clk_ctrl_pkg.sv]
// Register map, field positions and reset values of the clock controller
package clk_ctrl_pkg;
    // Register byte offsets
    localparam logic [7:0] OSC_MODE_OFS   = 8'h00;
    localparam logic [7:0] RUN_STOP_OFS   = 8'h04;
    localparam logic [7:0] SYS_SEL_OFS    = 8'h08;
    localparam logic [7:0] PER_GATE_OFS   = 8'h0C;
    localparam logic [7:0] SPEED_MODE_OFS = 8'h10;
    // high_speed_osc_mode fields
    localparam int EXT_CLOCK_SELECT_BIT  = 7;
    localparam int OSC_PIN_SELECT_BIT    = 6;
    localparam int CRYSTAL_FREQ_RANGE_BIT = 0;
    // oscillator_run_stop fields
    localparam int CRYSTAL_STOP_BIT      = 7;
    localparam int RUN_STOP_FIXED_BIT    = 6;
    localparam int INTERNAL_OSC_STOP_BIT = 0;
    // system_clock_select fields
    localparam int MAIN_CLOCK_STATUS_BIT = 5;
    localparam int MAIN_CLOCK_SOURCE_BIT = 4;
    // peripheral_clock_gate fields
    localparam int INTERVAL_TIMER_BIT = 7;
    localparam int CONVERTER_BIT      = 5;
    localparam int I2C_UNIT_BIT       = 4;
    localparam int SERIAL_SECOND_BIT  = 3;
    localparam int SERIAL_FIRST_BIT   = 2;
    localparam int TIMER_ARRAY_BIT    = 0;
    // speed_mode_register field
    localparam int LOW_SPEED_TIMER_BIT = 4;
    // Writable masks
    localparam logic [7:0] OSC_MODE_MASK   = 8'hC1;
    localparam logic [7:0] RUN_STOP_MASK   = 8'h81;
    localparam logic [7:0] SYS_SEL_MASK    = 8'h10;
    localparam logic [7:0] PER_GATE_MASK   = 8'hBD;
    localparam logic [7:0] SPEED_MODE_MASK = 8'h10;
    // Reset values
    localparam logic [7:0] OSC_MODE_RST   = 8'h00;
    localparam logic [7:0] RUN_STOP_RST   = 8'hC0;
    localparam logic [7:0] SYS_SEL_RST    = 8'h00;
    localparam logic [7:0] PER_GATE_RST   = 8'h00;
    localparam logic [7:0] SPEED_MODE_RST = 8'h00;
    // Switchover settle time
    localparam int CLK_HZ          = 50_000_000;
    localparam int SWITCH_SETTLE_NS = 200;
    localparam int SWITCH_CYCLES   =
        (SWITCH_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Pin modes
    typedef enum logic [1:0] {
        PIN_PORT, PIN_CRYSTAL, PIN_EXT_CLOCK
    } pin_mode_t;
    // Switchover states
    typedef enum logic [1:0] {
        SW_IDLE, SW_WAIT
    } switch_state_t;
endpackage : clk_ctrl_pkg

// [rtl/clk_switch_seq.sv]
// Main clock switchover sequencer with settle count
`timescale 1ns/10ps
`default_nettype none
module clk_switch_seq (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Request and status
    input  wire logic source_sel,
    output var  logic status_q
);
    import clk_ctrl_pkg::*;

    switch_state_t state_q;
    logic [7:0]    count_q;

    // Status follows the request only after the settle time has run
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q  <= SW_IDLE;
            count_q  <= 8'h00;
            status_q <= 1'b0;
        end else begin
            case (state_q)
                SW_IDLE: begin
                    if (source_sel != status_q) begin
                        state_q <= SW_WAIT;
                        count_q <= 8'(SWITCH_CYCLES - 1);
                    end
                end
                SW_WAIT: begin
                    if (source_sel == status_q) begin
                        state_q <= SW_IDLE;
                    end else if (count_q == 8'h00) begin
                        status_q <= source_sel;
                        state_q  <= SW_IDLE;
                    end else begin
                        count_q <= count_q - 8'h01;
                    end
                end
                default: state_q <= SW_IDLE;
            endcase
        end
    end

    chk_status_after_settle: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $changed(status_q) |-> $past(source_sel, 1) == status_q
            && $past(source_sel, SWITCH_CYCLES) == status_q)
        else $error("main clock status changed before settle");
endmodule : clk_switch_seq
`default_nettype wire

// [rtl/clk_ctrl.sv]
// Clock source and gating controller with AHB-Lite register slave
// Function
// - Range bit picks 1-10 or 10-20 MHz
// - Two pin bits select port, crystal, external
// - Internal oscillator stop bit halts fast oscillator
// - Crystal stop acts per pin mode
// - Source bit picks internal or high-speed clock
// - Status bit reports current main clock
// - Timer array gate: clock, writes, reset
// - First serial unit gate: clock, writes, reset; second gate only reads back
// - Second serial gate only on large variant
// - I2C gate: clock, writes, reset
// - Converter gate: clock, writes, reset
// - Interval timer gate: clock, writes, reset
// - Low-speed timer select gates slow oscillator
`timescale 1ns/10ps
`default_nettype none
module clk_ctrl #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    // Oscillator control
    output var  logic        fast_internal_osc_en,
    output var  logic        crystal_osc_en,
    output var  logic        ext_clock_in_en,
    output var  logic        crystal_high_range,
    output var  logic [1:0]  pin_mode,
    output var  logic        main_clock_is_high_speed,
    output var  logic        slow_osc_timer_clk_en,
    // Peripheral clock enables and write permits
    output var  logic [4:0]  periph_clk_en,
    output var  logic [4:0]  periph_wr_en,
    // Peripheral resets, active low
    output var  logic [4:0]  periph_rst_n
);
    import clk_ctrl_pkg::*;

    // Peripheral order: timer array, serial first, serial second, i2c,
    // converter, interval timer
    logic [7:0] osc_mode_q;
    logic [7:0] run_stop_q;
    logic [7:0] sys_sel_q;
    logic [7:0] per_gate_q;
    logic [7:0] speed_mode_q;
    logic       status_q;
    logic       wr_pend_q;
    logic [7:0] wr_addr_q;
    logic       rd_pend_q;
    logic       dphase_ok_q;
    logic [5:0] gate_vec;
    logic       access;

    function automatic pin_mode_t decode_pin(input logic [7:0] m);
        case ({m[EXT_CLOCK_SELECT_BIT], m[OSC_PIN_SELECT_BIT]})
            2'b01:   decode_pin = PIN_CRYSTAL;
            2'b11:   decode_pin = PIN_EXT_CLOCK;
            default: decode_pin = PIN_PORT;
        endcase
    endfunction : decode_pin

    function automatic logic [7:0] reg_read(input logic [7:0] a,
                                            input logic [7:0] om,
                                            input logic [7:0] rs,
                                            input logic [7:0] ss,
                                            input logic [7:0] pg,
                                            input logic [7:0] sm);
        case (a)
            OSC_MODE_OFS:   reg_read = om;
            RUN_STOP_OFS:   reg_read = rs;
            SYS_SEL_OFS:    reg_read = ss;
            PER_GATE_OFS:   reg_read = pg;
            SPEED_MODE_OFS: reg_read = sm;
            default:        reg_read = 8'h00;
        endcase
    endfunction : reg_read

    assign access = hsel && hready && htrans[1];

    // Address phase capture; zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= access && hwrite;
            rd_pend_q <= access && !hwrite;
            if (access) begin
                wr_addr_q <= haddr[7:0];
            end
        end
    end

    // Bus answer outputs: always ready, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            dphase_ok_q <= 1'b0;
        end else begin
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            dphase_ok_q <= access;
        end
    end

    // Read data registered at address phase, valid in data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (access && !hwrite) begin
            hrdata <= {24'h00_0000, reg_read(haddr[7:0], osc_mode_q,
                run_stop_q,
                {sys_sel_q[7:6], status_q, sys_sel_q[4:0]},
                per_gate_q, speed_mode_q)};
        end
    end

    // Register writes in data phase; the hidden variant bit stays zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_mode_q   <= OSC_MODE_RST;
            run_stop_q   <= RUN_STOP_RST;
            sys_sel_q    <= SYS_SEL_RST;
            per_gate_q   <= PER_GATE_RST;
            speed_mode_q <= SPEED_MODE_RST;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                OSC_MODE_OFS:
                    osc_mode_q <= hwdata[7:0] & OSC_MODE_MASK;
                RUN_STOP_OFS:
                    run_stop_q <= (hwdata[7:0] & RUN_STOP_MASK)
                        | RUN_STOP_RST & ~RUN_STOP_MASK;
                SYS_SEL_OFS:
                    sys_sel_q <= hwdata[7:0] & SYS_SEL_MASK;
                PER_GATE_OFS: begin
                    per_gate_q <= hwdata[7:0] & PER_GATE_MASK;
                    if (!LARGE_VARIANT)
                        per_gate_q[SERIAL_SECOND_BIT] <= 1'b0;
                end
                SPEED_MODE_OFS:
                    speed_mode_q <= hwdata[7:0] & SPEED_MODE_MASK;
                default: ;
            endcase
        end
    end

    // Main clock switchover; status moves only once settled
    clk_switch_seq u_switch (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .source_sel (sys_sel_q[MAIN_CLOCK_SOURCE_BIT]),
        .status_q   (status_q)
    );

    assign gate_vec = {per_gate_q[INTERVAL_TIMER_BIT],
                       per_gate_q[CONVERTER_BIT],
                       per_gate_q[I2C_UNIT_BIT],
                       per_gate_q[SERIAL_SECOND_BIT],
                       per_gate_q[SERIAL_FIRST_BIT],
                       per_gate_q[TIMER_ARRAY_BIT]};

    // Oscillator and pin outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fast_internal_osc_en     <= 1'b1;
            crystal_osc_en           <= 1'b0;
            ext_clock_in_en          <= 1'b0;
            crystal_high_range       <= 1'b0;
            pin_mode                 <= PIN_PORT;
            main_clock_is_high_speed <= 1'b0;
            slow_osc_timer_clk_en    <= 1'b0;
        end else begin
            fast_internal_osc_en <=
                !run_stop_q[INTERNAL_OSC_STOP_BIT];
            crystal_osc_en <= decode_pin(osc_mode_q) == PIN_CRYSTAL
                && !run_stop_q[CRYSTAL_STOP_BIT];
            ext_clock_in_en <= decode_pin(osc_mode_q) == PIN_EXT_CLOCK
                && !run_stop_q[CRYSTAL_STOP_BIT];
            crystal_high_range <=
                osc_mode_q[CRYSTAL_FREQ_RANGE_BIT];
            pin_mode <= decode_pin(osc_mode_q);
            main_clock_is_high_speed <= status_q;
            slow_osc_timer_clk_en <=
                speed_mode_q[LOW_SPEED_TIMER_BIT];
        end
    end

    // Peripheral gates; the second serial unit has no output lane, so its
    // gate bit only reads back
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            periph_clk_en <= 5'h00;
            periph_wr_en  <= 5'h00;
            periph_rst_n  <= 5'h00;
        end else begin
            // Lanes: 0 timer array, 1 serial first, 2 i2c, 3 converter,
            // 4 interval timer; gate_vec[2] is the lane-less serial unit
            periph_clk_en <= {gate_vec[5], gate_vec[4], gate_vec[3],
                              gate_vec[1], gate_vec[0]};
            periph_wr_en  <= {gate_vec[5], gate_vec[4], gate_vec[3],
                              gate_vec[1], gate_vec[0]};
            periph_rst_n  <= {gate_vec[5], gate_vec[4], gate_vec[3],
                              gate_vec[1], gate_vec[0]};
        end
    end

    chk_crystal_mode_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        crystal_osc_en |-> $past(decode_pin(osc_mode_q)) == PIN_CRYSTAL
            && !$past(run_stop_q[CRYSTAL_STOP_BIT]))
        else $error("crystal enabled outside oscillation mode");
    chk_ext_clock_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ext_clock_in_en == ($past(decode_pin(osc_mode_q)) == PIN_EXT_CLOCK
            && !$past(run_stop_q[CRYSTAL_STOP_BIT])))
        else $error("external clock enable wrong");
    chk_internal_osc_stop: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(run_stop_q[INTERNAL_OSC_STOP_BIT]) |=> !fast_internal_osc_en)
        else $error("internal oscillator not halted");
    chk_freq_range_out: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $changed(osc_mode_q[CRYSTAL_FREQ_RANGE_BIT]) |=>
            crystal_high_range == $past(osc_mode_q[CRYSTAL_FREQ_RANGE_BIT]))
        else $error("frequency range output stale");
    chk_status_lags_source: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(sys_sel_q[MAIN_CLOCK_SOURCE_BIT]) && !status_q |=>
            !status_q)
        else $error("status switched without settling");
    chk_status_follows_source: assert property (
        @(posedge hclk) disable iff (!hresetn)
        sys_sel_q[MAIN_CLOCK_SOURCE_BIT] [*8] ##1
            sys_sel_q[MAIN_CLOCK_SOURCE_BIT] [*4] |-> status_q)
        else $error("status never reached selected source");
    chk_status_follows_low: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (!sys_sel_q[MAIN_CLOCK_SOURCE_BIT]) [*8] ##1
            (!sys_sel_q[MAIN_CLOCK_SOURCE_BIT]) [*4] |-> !status_q)
        else $error("status never returned to internal clock");
    chk_pin_mode_out: assert property (
        @(posedge hclk) disable iff (!hresetn)
        pin_mode == $past(decode_pin(osc_mode_q)))
        else $error("pin mode output wrong");
    chk_gate_timer_reset: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !per_gate_q[TIMER_ARRAY_BIT] |=> !periph_clk_en[0]
            && !periph_wr_en[0] && !periph_rst_n[0])
        else $error("timer array not gated off");
    chk_gate_interval_on: assert property (
        @(posedge hclk) disable iff (!hresetn)
        per_gate_q[INTERVAL_TIMER_BIT] |=> periph_clk_en[4]
            && periph_wr_en[4] && periph_rst_n[4])
        else $error("interval timer not enabled");
    chk_gate_serial_on: assert property (
        @(posedge hclk) disable iff (!hresetn)
        per_gate_q[SERIAL_FIRST_BIT] |=> periph_clk_en[1]
            && periph_wr_en[1] && periph_rst_n[1])
        else $error("first serial unit not enabled");
    chk_gate_i2c_off: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !per_gate_q[I2C_UNIT_BIT] |=> !periph_clk_en[2]
            && !periph_wr_en[2] && !periph_rst_n[2])
        else $error("i2c unit not gated off");
    chk_gate_converter_off: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !per_gate_q[CONVERTER_BIT] |=> !periph_clk_en[3]
            && !periph_wr_en[3] && !periph_rst_n[3])
        else $error("converter not gated off");
    chk_hidden_variant_bit: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !LARGE_VARIANT |-> !per_gate_q[SERIAL_SECOND_BIT])
        else $error("second serial bit set on small variant");
    chk_slow_timer_clock: assert property (
        @(posedge hclk) disable iff (!hresetn)
        slow_osc_timer_clk_en == $past(speed_mode_q[LOW_SPEED_TIMER_BIT]))
        else $error("slow timer clock select wrong");

    cov_switch_to_high: cover property (
        @(posedge hclk) disable iff (!hresetn) $rose(status_q));
    cov_crystal_run: cover property (
        @(posedge hclk) disable iff (!hresetn) $rose(crystal_osc_en));
    cov_ext_clock_run: cover property (
        @(posedge hclk) disable iff (!hresetn) $rose(ext_clock_in_en));
    cov_read_data_phase: cover property (
        @(posedge hclk) disable iff (!hresetn) dphase_ok_q && rd_pend_q);
endmodule : clk_ctrl
`default_nettype wire

// [verif/clk_ctrl_tb_top.sv]
// Self-checking bench for the clock source and gating controller
`timescale 1ns/10ps
`default_nettype none
module clk_ctrl_tb_top;
    import clk_ctrl_pkg::*;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire  logic  hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        fast_en, xtal_en, ext_en, hi_range, main_hs, slow_en;
    logic [1:0]  pin_mode;
    logic [4:0]  clk_en, wr_en, rst_n;
    int          errors;
    int          num_checks;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    clk_ctrl #(.LARGE_VARIANT(1'b1)) i_clk_ctrl (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .fast_internal_osc_en(fast_en),
        .crystal_osc_en(xtal_en), .ext_clock_in_en(ext_en),
        .crystal_high_range(hi_range), .pin_mode(pin_mode),
        .main_clock_is_high_speed(main_hs),
        .slow_osc_timer_clk_en(slow_en), .periph_clk_en(clk_en),
        .periph_wr_en(wr_en), .periph_rst_n(rst_n)
    );

    always #10 hclk = ~hclk;

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t read %h expected %h", $time, got, exp);
        end
    endtask : cmp_reg

    task automatic cmp_pins(input logic [22:0] got, input logic [22:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t outputs %h expected %h", $time, got, exp);
        end
    endtask : cmp_pins

    task automatic cmp_resp(input logic got);
        num_checks++;
        if (got !== 1'b0) begin
            errors++;
            $display("[ERR] %0t bus response not OKAY", $time);
        end
    endtask : cmp_resp

    // Bounded wait: a stuck ready ends the run rather than hanging it
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            errors++;
            $display("[ERR] %0t bus ready timeout", $time);
            close_out();
        end
    endtask : wait_rdy

    task automatic bus(input logic [7:0] ofs, input logic w,
                       input logic [7:0] d);
        haddr  <= {24'h000000, ofs};
        hwrite <= w;
        hsize  <= 3'b010;
        htrans <= 2'b10;
        hsel   <= 1'b1;
        wait_rdy();
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= {24'h000000, d};
        wait_rdy();
        cmp_resp(hresp);
    endtask : bus

    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        bus(ofs, 1'b1, d);
    endtask : wr

    task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
        bus(ofs, 1'b0, 8'h00);
        cmp_reg(hrdata, {24'h000000, exp});
    endtask : rd_chk

    // Outputs follow a register write one cycle later; allow margin
    task automatic chk_pins(input logic [7:0] osc, input logic [4:0] per);
        repeat (2) @(posedge hclk);
        #1;
        cmp_pins({fast_en, xtal_en, ext_en, hi_range, pin_mode, main_hs,
                  slow_en, clk_en, wr_en, rst_n}, {osc, per, per, per});
        @(posedge hclk);
    endtask : chk_pins

    task automatic chk_reset;
        rd_chk(OSC_MODE_OFS, OSC_MODE_RST);
        rd_chk(RUN_STOP_OFS, RUN_STOP_RST);
        rd_chk(SYS_SEL_OFS, SYS_SEL_RST);
        rd_chk(PER_GATE_OFS, PER_GATE_RST);
        rd_chk(SPEED_MODE_OFS, SPEED_MODE_RST);
        rd_chk(8'h14, 8'h00);
        chk_pins(8'h80, 5'h00);
        $display("test reset values done");
    endtask : chk_reset

    initial begin
        int          lane_bit [5];
        logic [1:0]  pm;
        logic        stp;
        lane_bit = '{0, 2, 4, 5, 7};
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        errors = 0;
        num_checks = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        chk_reset();
        // Unmapped place: write dropped, reads zero
        wr(8'h14, 8'hFF);
        rd_chk(8'h14, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(PER_GATE_OFS, 8'h01 << lane_bit[i]);
            rd_chk(PER_GATE_OFS, 8'h01 << lane_bit[i]);
            chk_pins(8'h80, 5'h01 << i);
        end
        wr(PER_GATE_OFS, 8'h08);
        rd_chk(PER_GATE_OFS, 8'h08);
        chk_pins(8'h80, 5'h00);
        wr(PER_GATE_OFS, 8'hFF);
        rd_chk(PER_GATE_OFS, 8'hBD);
        chk_pins(8'h80, 5'h1F);
        wr(PER_GATE_OFS, 8'h00);
        $display("test peripheral gates done");
        wr(SPEED_MODE_OFS, 8'hFF);
        rd_chk(SPEED_MODE_OFS, 8'h10);
        chk_pins(8'h81, 5'h00);
        wr(SPEED_MODE_OFS, 8'h00);
        chk_pins(8'h80, 5'h00);
        $display("test speed mode done");
        wr(RUN_STOP_OFS, 8'h01);
        rd_chk(RUN_STOP_OFS, 8'h41);
        chk_pins(8'h00, 5'h00);
        for (int m = 0; m < 8; m++) begin
            pm  = m[1:0];
            stp = m[2];
            wr(OSC_MODE_OFS, {pm, 5'h00, pm[0]});
            wr(RUN_STOP_OFS, {stp, 7'h00});
            rd_chk(OSC_MODE_OFS, {pm, 5'h00, pm[0]});
            chk_pins({1'b1, pm == 2'b01 && !stp, pm == 2'b11 && !stp, pm[0],
                      pm == 2'b01 ? 2'd1 : pm == 2'b11 ? 2'd2 : 2'd0,
                      2'b00}, 5'h00);
        end
        $display("test pin modes done");
        // Status lags the source bit by the settle count
        wr(SYS_SEL_OFS, 8'h10);
        rd_chk(SYS_SEL_OFS, 8'h10);
        repeat (SWITCH_CYCLES + 5) @(posedge hclk);
        rd_chk(SYS_SEL_OFS, 8'h30);
        // External clock mode with its input stopped is left from above
        chk_pins(8'h9A, 5'h00);
        wr(SYS_SEL_OFS, 8'h00);
        wr(SYS_SEL_OFS, 8'h10);
        repeat (SWITCH_CYCLES + 5) @(posedge hclk);
        rd_chk(SYS_SEL_OFS, 8'h30);
        wr(SYS_SEL_OFS, 8'h20);
        rd_chk(SYS_SEL_OFS, 8'h20);
        repeat (SWITCH_CYCLES + 5) @(posedge hclk);
        rd_chk(SYS_SEL_OFS, 8'h00);
        chk_pins(8'h98, 5'h00);
        $display("test main clock switch done");
        // Second reset mid-run restores every register
        wr(PER_GATE_OFS, 8'hBD);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        chk_reset();
        close_out();
    end
endmodule : clk_ctrl_tb_top
`default_nettype wire
